//--- src/uam_addr_match.sv
// multiprocessor address recognition and receive load for the serial port
module uam_addr_match
   import uam_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_reset,
   input  wire uam_sfr_req_t i_sfr,
   input  wire logic [1:0]   i_serial_mode,
   input  wire logic         i_multiproc_mode_enable,
   input  wire uam_frame_t   i_frame,
   input  wire logic         i_receive_complete_clear,
   output logic [7:0]        o_sfr_rdata,
   output logic              o_sfr_rvalid,
   output logic              o_receive_complete_flag,
   output logic [7:0]        o_serial_data_holding,
   output logic              o_received_ninth_bit,
   output logic              o_frame_accepted
);
   uam_state_t s_q;
   uam_state_t s_d;
   logic [7:0] given_care;
   logic [7:0] bcast_care;
   logic       given_hit;
   logic       bcast_hit;
   logic       addr_hit;
   logic       nine_bit_mode;
   logic       qualify;
   logic       accept;

   // mask bits of 1 take part, others are don't care
   assign given_care = s_q.slave_address_mask;
   assign given_hit  = ((i_frame.data ^ s_q.slave_address) & given_care) == 8'h00;
   // broadcast: zero bits of the OR are don't care
   assign bcast_care = s_q.slave_address | s_q.slave_address_mask;
   assign bcast_hit  = ((i_frame.data ^ bcast_care) & bcast_care) == 8'h00;
   assign addr_hit   = given_hit | bcast_hit;

   assign nine_bit_mode = (i_serial_mode == UAM_MODE_2) || (i_serial_mode == UAM_MODE_3);

   // ninth bit is the address marker in modes 2/3 and the stop bit in mode 1
   always_comb
   begin
      if (!i_multiproc_mode_enable)
      begin
         // addressed slave turns the mode off to take its data frames
         qualify = 1'b1;
      end
      else if (nine_bit_mode || i_serial_mode == UAM_MODE_1)
      begin
         // only ninth-bit-high frames can match; data frames are skipped
         qualify = i_frame.ninth && addr_hit;
      end
      else
      begin
         qualify = 1'b1;
      end
   end

   // a full holding register drops the new frame rather than overwrite it
   assign accept = i_frame.done && !s_q.receive_complete_flag && qualify;

   always_comb
   begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;
      s_d.rdata  = 8'h00;
      if (i_sfr.wr)
      begin
         case (i_sfr.addr)
            UAM_SLAVE_ADDRESS_OFS:      s_d.slave_address      = i_sfr.wdata;
            UAM_SLAVE_ADDRESS_MASK_OFS: s_d.slave_address_mask = i_sfr.wdata;
            default:                    s_d.slave_address      = s_q.slave_address;
         endcase
      end
      if (i_sfr.rd)
      begin
         s_d.rvalid = 1'b1;
         case (i_sfr.addr)
            UAM_SLAVE_ADDRESS_OFS:      s_d.rdata = s_q.slave_address;
            UAM_SLAVE_ADDRESS_MASK_OFS: s_d.rdata = s_q.slave_address_mask;
            default:                    s_d.rdata = 8'h00;
         endcase
      end
      if (i_receive_complete_clear)
      begin
         s_d.receive_complete_flag = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (accept)
      begin
         s_d.serial_data_holding   = i_frame.data;
         s_d.received_ninth_bit    = i_frame.ninth;
         s_d.receive_complete_flag = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         s_q                       <= '0;
         s_q.slave_address         <= UAM_SLAVE_ADDRESS_RST;
         s_q.slave_address_mask    <= UAM_SLAVE_ADDRESS_MASK_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_sfr_rdata             = s_q.rdata;
   assign o_sfr_rvalid            = s_q.rvalid;
   assign o_receive_complete_flag = s_q.receive_complete_flag;
   assign o_serial_data_holding   = s_q.serial_data_holding;
   assign o_received_ninth_bit    = s_q.received_ninth_bit;
   assign o_frame_accepted        = accept;

   a_mp_off_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && !i_multiproc_mode_enable && !o_receive_complete_flag) |=> o_receive_complete_flag)
      else $error("frame lost with multiprocessor mode off");

   a_nomatch_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && i_multiproc_mode_enable && nine_bit_mode && !addr_hit && !o_receive_complete_flag
       && !i_receive_complete_clear) |=> (!o_receive_complete_flag && $stable(o_serial_data_holding)))
      else $error("non-matching address changed receive state");

   a_data_skipped: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && i_multiproc_mode_enable && nine_bit_mode && !i_frame.ninth) |-> !accept)
      else $error("data frame accepted in multiprocessor mode");

   a_match_loads: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && i_multiproc_mode_enable && i_frame.ninth && addr_hit && !o_receive_complete_flag
       && i_serial_mode != UAM_MODE_0) |=> (o_receive_complete_flag && o_serial_data_holding == $past(i_frame.data)))
      else $error("matching address not loaded");

   a_full_blocks: assert property (@(posedge i_core_clk) disable iff (i_reset)
      o_receive_complete_flag |-> !accept)
      else $error("load while flag already set");

   a_mode1_stop: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && i_multiproc_mode_enable && i_serial_mode == UAM_MODE_1 && !i_frame.ninth) |-> !accept)
      else $error("mode 1 frame without stop bit accepted");

   a_given_match: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (((i_frame.data & s_q.slave_address_mask) == (s_q.slave_address & s_q.slave_address_mask))) |-> addr_hit)
      else $error("given address missed");

   a_bcast_match: assert property (@(posedge i_core_clk) disable iff (i_reset)
      ((i_frame.data & (s_q.slave_address | s_q.slave_address_mask))
        == (s_q.slave_address | s_q.slave_address_mask)) |-> addr_hit)
      else $error("broadcast address missed");

   a_reg_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_sfr.wr && i_sfr.addr == UAM_SLAVE_ADDRESS_MASK_OFS) |=> s_q.slave_address_mask == $past(i_sfr.wdata))
      else $error("mask write lost");

   a_reset_open: assert property (@(posedge i_core_clk)
      $fell(i_reset) |-> (s_q.slave_address == 8'h00 && s_q.slave_address_mask == 8'h00 && addr_hit))
      else $error("reset did not open address match");

   a_set_beats_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (accept && i_receive_complete_clear) |=> o_receive_complete_flag)
      else $error("clear won over a frame load");

   a_ninth_loaded: assert property (@(posedge i_core_clk) disable iff (i_reset)
      accept |=> (o_received_ninth_bit == $past(i_frame.ninth)))
      else $error("ninth bit not loaded with the byte");

   a_read_pulse: assert property (@(posedge i_core_clk) disable iff (i_reset)
      i_sfr.rd |=> o_sfr_rvalid)
      else $error("read not answered next cycle");

   a_reject_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_frame.done && !accept && !i_receive_complete_clear && !o_receive_complete_flag)
      |=> (!o_receive_complete_flag && $stable(o_serial_data_holding)))
      else $error("refused frame changed receive state");
endmodule

//--- src/uam_pkg.sv
// package for the serial port multiprocessor address match block
package uam_pkg;
   localparam logic [7:0] UAM_SLAVE_ADDRESS_OFS      = 8'hA9;
   localparam logic [7:0] UAM_SLAVE_ADDRESS_MASK_OFS = 8'hB9;
   localparam logic [7:0] UAM_SLAVE_ADDRESS_RST      = 8'h00;
   localparam logic [7:0] UAM_SLAVE_ADDRESS_MASK_RST = 8'h00;
   localparam logic [1:0] UAM_MODE_0                 = 2'h0;
   localparam logic [1:0] UAM_MODE_1                 = 2'h1;
   localparam logic [1:0] UAM_MODE_2                 = 2'h2;
   localparam logic [1:0] UAM_MODE_3                 = 2'h3;

   // special function register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } uam_sfr_req_t;

   // completed frame from the receive shifter
   typedef struct packed {
      logic       done;
      logic [7:0] data;
      logic       ninth;
   } uam_frame_t;

   typedef struct packed {
      logic [7:0] slave_address;
      logic [7:0] slave_address_mask;
      logic [7:0] serial_data_holding;
      logic       received_ninth_bit;
      logic       receive_complete_flag;
      logic [7:0] rdata;
      logic       rvalid;
   } uam_state_t;
endpackage

//--- verif/uam_master_model.sv
// master processor model sending completed frames to the receiver
module uam_master_model
   import uam_pkg::*;
(
   input  wire logic i_core_clk,
   output uam_frame_t o_frame
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_frame = '{done: 1'b0, data: 8'hFF, ninth: 1'b1};
   // one completed frame per call, done held high for one cycle
   task automatic send(input logic [7:0] d, input logic n);
      @(posedge i_core_clk) #1;
      o_frame = '{done: 1'b1, data: d, ninth: n}; // address has ninth 1, data 0
      @(posedge i_core_clk) #1;
      // inverted after release so stale values cannot pass
      o_frame = '{done: 1'b0, data: ~d, ninth: ~n};
   endtask
endmodule

//--- verif/uam_addr_match_test.sv
// self-checking bench for the address match block
module uam_addr_match_test
   import uam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] mode;
      logic       mp;
      logic [7:0] sa;
      logic [7:0] mk;
      logic [7:0] d;
      logic       n;
      logic       acc;
   } uam_row_t;
   logic         i_core_clk, i_reset, mp, clr, flag, rvalid, ninth_q, acc, acc_seen;
   logic [1:0]   mode;
   logic [7:0]   rdata, hold, exp_hold;
   uam_sfr_req_t sfr_req;
   uam_frame_t   frame;
   uam_row_t     r;
   int           n_fail = 0;
   int           checks_done = 0;
   uam_row_t rows [10] = '{
      '{2'h2, 1'b1, 8'hA4, 8'hFA, 8'hA0, 1'b1, 1'b1}, '{2'h3, 1'b1, 8'hA4, 8'hFA, 8'hA3, 1'b1, 1'b0},
      '{2'h3, 1'b1, 8'hA4, 8'hFA, 8'hFF, 1'b1, 1'b1}, '{2'h2, 1'b1, 8'hA4, 8'hFA, 8'hA0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 8'hA4, 8'hFA, 8'h33, 1'b0, 1'b1}, '{2'h1, 1'b1, 8'hA4, 8'hFA, 8'hA0, 1'b0, 1'b0},
      '{2'h1, 1'b1, 8'hA4, 8'hFA, 8'hA0, 1'b1, 1'b1}, '{2'h2, 1'b1, 8'hA7, 8'hF9, 8'hA3, 1'b1, 1'b1},
      '{2'h2, 1'b1, 8'hA7, 8'hF9, 8'hA0, 1'b1, 1'b0}, '{2'h0, 1'b1, 8'hA7, 8'hF9, 8'h12, 1'b0, 1'b1}};
   uam_addr_match i_uam_addr_match (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_sfr(sfr_req),
      .i_serial_mode(mode), .i_multiproc_mode_enable(mp), .i_frame(frame), .i_receive_complete_clear(clr),
      .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid), .o_receive_complete_flag(flag),
      .o_serial_data_holding(hold), .o_received_ninth_bit(ninth_q), .o_frame_accepted(acc));
   uam_master_model i_uam_master_model (.i_core_clk(i_core_clk), .o_frame(frame));
   always @(posedge i_core_clk) if (frame.done) acc_seen <= acc;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // read checks data against d, write stores d
   task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk) #1;
      sfr_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(posedge i_core_clk) #1;
      sfr_req = '0;
      if (!wr)
      begin
         cmp(8'(rvalid), 8'h01);
         cmp(rdata, d);
      end
   endtask
   task automatic pulse_clr;
      @(posedge i_core_clk) #1;
      clr = 1'b1;
      @(posedge i_core_clk) #1;
      clr = 1'b0;
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end
   initial
   begin
      #100000;
      n_fail++;
      wrap_up();
   end
   initial
   begin
      {i_reset, mp, clr, mode, sfr_req, exp_hold} = {1'b1, 1'b0, 1'b0, 2'h2, 18'h00000, 8'h00};
      repeat (4) @(posedge i_core_clk);
      #1 i_reset = 1'b0;
      foreach (rows[k])
      begin
         r = rows[k];
         sfr(1'b1, UAM_SLAVE_ADDRESS_OFS, r.sa);
         sfr(1'b1, UAM_SLAVE_ADDRESS_MASK_OFS, r.mk);
         pulse_clr();
         {mode, mp} = {r.mode, r.mp};
         i_uam_master_model.send(r.d, r.n);
         if (r.acc)
            exp_hold = r.d;
         cmp(8'(acc_seen), 8'(r.acc));
         cmp(8'(flag), 8'(r.acc));
         cmp(hold, exp_hold);
         if (r.acc)
            cmp(8'(ninth_q), 8'(r.n));
      end
      // flag still set: frame must be dropped
      {mode, mp} = {UAM_MODE_2, 1'b0};
      i_uam_master_model.send(8'hC3, 1'b0);
      cmp(8'(acc_seen), 8'h00);
      cmp(hold, exp_hold);
      sfr(1'b0, UAM_SLAVE_ADDRESS_OFS, 8'hA7);
      sfr(1'b0, UAM_SLAVE_ADDRESS_MASK_OFS, 8'hF9);
      sfr(1'b0, 8'h99, 8'h00);
      // second reset mid-run
      @(posedge i_core_clk) #1 i_reset = 1'b1;
      @(posedge i_core_clk) #1 i_reset = 1'b0;
      cmp({hold[6:0], flag}, 8'h00);
      cmp({7'h00, hold[7] | ninth_q}, 8'h00);
      sfr(1'b0, UAM_SLAVE_ADDRESS_OFS, UAM_SLAVE_ADDRESS_RST);
      sfr(1'b0, UAM_SLAVE_ADDRESS_MASK_OFS, UAM_SLAVE_ADDRESS_MASK_RST);
      {mode, mp} = {UAM_MODE_3, 1'b1};
      i_uam_master_model.send(8'h5A, 1'b1);
      cmp(8'(flag), 8'h01);
      cmp(hold, 8'h5A);
      wrap_up();
   end
endmodule
